/* shared/spc_pkg.sv */
// constants, register map and types for the serial port control block
// assumes an apb slave on mclk with byte addresses equal to printed offsets times four
// Functional notes
// - enable gives shared terminals their serial roles
// - mode field selects async8 async7 slave master
// - clock field selects timer or osc divide
// - slave mode shifts on external clock
// - parity enable appends and checks parity
// - parity only active in async modes
// - parity type odd when one, even else
// - transmit enable bit gates transmission
// - transmit trigger starts send, reads busy
// - receive enable bit gates reception
// - sync receive trigger starts a reception
// - slave trigger write drives ready low
// - async trigger empties buffer, else overrun
// - receive trigger reads busy in all modes
// - data write loads transmit shifter
// - async7 ignores data msb on transmit
// - data read returns receive buffer
// - async7 with parity loads zero msb
// - error flags clear on writing one
// - three interrupt enables at bits two..zero
// - three interrupt flags clear on one
// - priority field bits five four
// - parity mismatch sets error, still stores
// - zero stop bit sets framing error
// - overrun skips done flag, error precedes
// - error flags held zero while rx off
package spc_pkg;
  localparam logic [15:0] SPC_IDX_PRIO = 16'hff20;
  localparam logic [15:0] SPC_IDX_IEN = 16'hff23;
  localparam logic [15:0] SPC_IDX_IFLG = 16'hff25;
  localparam logic [15:0] SPC_IDX_MODE = 16'hff48;
  localparam logic [15:0] SPC_IDX_CTRL = 16'hff49;
  localparam logic [15:0] SPC_IDX_DATA = 16'hff4a;
  // control register bit positions
  localparam int SPC_B_TRANSMIT_ENABLE = 0;
  localparam int SPC_B_TRANSMIT_TRIGGER = 1;
  localparam int SPC_B_RECEIVE_ENABLE = 2;
  localparam int SPC_B_RECEIVE_TRIGGER = 3;
  localparam int SPC_B_OVR = 4;
  localparam int SPC_B_PAR = 5;
  localparam int SPC_B_FRM = 6;
  // interrupt bit positions
  localparam int SPC_B_TXI = 0;
  localparam int SPC_B_RXI = 1;
  localparam int SPC_B_ERI = 2;
  localparam logic [7:0] SPC_RST_BYTE = 8'h00;
  localparam logic [1:0] SPC_MODE_MASTER = 2'h0;
  localparam logic [1:0] SPC_MODE_SLAVE = 2'h1;
  localparam logic [1:0] SPC_MODE_A7 = 2'h2;
  localparam logic [1:0] SPC_MODE_A8 = 2'h3;
  localparam logic [1:0] SPC_CLK_TIMER = 2'h3;
  localparam logic [1:0] SPC_CLK_DIV4 = 2'h2;
  localparam logic [1:0] SPC_CLK_DIV8 = 2'h1;
  localparam logic [1:0] SPC_CLK_DIV16 = 2'h0;
  typedef enum logic [1:0] {SPC_IDLE, SPC_START, SPC_BITS, SPC_STOP} spc_phase_t;
endpackage : spc_pkg

/* rtl/spc_serial_port.sv */
// serial port control block: apb registers, async and clocked shifters
// assumes oscTick pulses once per high-speed oscillator cycle and timerTick once per
// timer underflow, both from mclk logic; pins are asynchronous and synchronised here
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
module spc_serial_port
  import spc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic oscTick,
  input wire logic timerTick,
  input wire logic serialInPin,
  input wire logic shiftClkIn,
  input wire logic readyIn,
  output logic serialOutPin,
  output logic shiftClkOut,
  output logic shiftClkOe,
  output logic readyPinOut,
  output logic readyPinOe,
  output logic portSerialSelect,
  output logic [1:0] serialIrqLevel,
  output logic [2:0] irqActive
);
  // full module state
  typedef struct packed {
    logic [7:0] prio;      // priority register
    logic [7:0] ien;       // interrupt enables
    logic [2:0] iflg;      // interrupt factor flags
    logic [6:0] mode;      // mode config bits 6..0
    logic transmit_enable;
    logic receive_enable;
    logic txBusy;          // transmit status
    logic rxBusy;          // receive status
    logic ovr;
    logic par;
    logic frm;
    logic [7:0] txData;    // transmit shift source
    logic [7:0] rxBuf;     // receive buffer
    logic bufFull;         // async buffer not yet released
    logic [3:0] div;       // oscillator divider
    logic [2:0] serial_in_pin;       // synchroniser chain for serial in (0,1) and last
    logic [2:0] sClk;      // synchroniser for shift clock
    logic [1:0] ready_pin;      // synchroniser for ready in
    spc_phase_t txPh;
    spc_phase_t rxPh;
    logic [3:0] txBit;
    logic [3:0] rxBit;
    logic [3:0] txTick;    // half bit ticks in async tx
    logic [3:0] rxTick;
    logic [9:0] txSh;
    logic [8:0] rxSh;
    logic txOut;
    logic clkOut;
    logic rdyOut;
    logic pendRec;         // receive done waits half a clock after error
    logic [31:0] rdata;
  } spc_state_t;

  spc_state_t s_r, s_nxt;

  logic [15:0] idx;           // printed offset from byte address
  logic wrAcc, rdAcc;
  logic [1:0] mode, clkSel;
  logic asyncMode, parOn, oddPar, halfTick;
  logic [7:0] wb;

  assign idx = paddr[17:2];
  assign wrAcc = psel & penable & pwrite;
  assign rdAcc = psel & ~penable & ~pwrite;
  assign wb = pwdata[7:0];
  assign mode = s_r.mode[2:1];
  assign clkSel = s_r.mode[4:3];
  assign asyncMode = mode[1];
  assign parOn = s_r.mode[6] & asyncMode;
  assign oddPar = s_r.mode[5];

  // half shift clock tick from selected source
  always_comb
  begin
    case (clkSel)
      SPC_CLK_TIMER: halfTick = timerTick;
      SPC_CLK_DIV4: halfTick = oscTick & (s_r.div[0] == 1'b1);
      SPC_CLK_DIV8: halfTick = oscTick & (s_r.div[1:0] == 2'h3);
      default: halfTick = oscTick & (s_r.div[2:0] == 3'h7);
    endcase
  end

  // next-state logic
  always_comb
  begin
    logic clkRise, clkFall, txDone, recEv, errEv, sync, fullAsync;
    logic ovrSet, parSet, frmSet; // hardware set of an error flag this cycle
    logic [7:0] dat;
    logic pbit;
    s_nxt = s_r;
    clkRise = 1'b0;
    clkFall = 1'b0;
    txDone = 1'b0;
    recEv = 1'b0;
    errEv = 1'b0;
    dat = 8'h00;
    pbit = 1'b0;
    sync = ~asyncMode;
    fullAsync = 1'b0;
    ovrSet = 1'b0;
    parSet = 1'b0;
    frmSet = 1'b0;
    // synchronisers: stage one only feeds stage two
    s_nxt.serial_in_pin = {s_r.serial_in_pin[1], s_r.serial_in_pin[0], serialInPin};
    s_nxt.sClk = {s_r.sClk[1], s_r.sClk[0], shiftClkIn};
    s_nxt.ready_pin = {s_r.ready_pin[0], readyIn};
    if (oscTick)
    begin
      s_nxt.div = s_r.div + 4'h1;
    end
    // shift clock edges: internal half ticks or external slave clock
    if (mode == SPC_MODE_SLAVE)
    begin
      clkFall = s_r.sClk[2] & ~s_r.sClk[1];
      clkRise = ~s_r.sClk[2] & s_r.sClk[1];
    end
    else if (halfTick && (s_r.txBusy || s_r.rxBusy || !s_r.clkOut))
    begin
      // clock stands high between transfers
      s_nxt.clkOut = ~s_r.clkOut;
      clkFall = s_r.clkOut;
      clkRise = ~s_r.clkOut;
    end
    // async transmitter: one bit per two half ticks
    if (asyncMode && s_r.txBusy && halfTick)
    begin
      s_nxt.txTick = s_r.txTick + 4'h1;
      if (s_r.txTick[0])
      begin
        s_nxt.txSh = {1'b1, s_r.txSh[9:1]};
        s_nxt.txOut = s_r.txSh[0];
        s_nxt.txBit = s_r.txBit - 4'h1;
        if (s_r.txBit == 4'h0)
        begin
          s_nxt.txBusy = 1'b0;
          s_nxt.txOut = 1'b1;
          txDone = 1'b1;
        end
      end
    end
    // sync transmitter: change on falling, done after last rising
    if (sync && s_r.txBusy && (clkFall || clkRise))
    begin
      if (clkFall)
      begin
        s_nxt.txOut = s_r.txSh[0];
        s_nxt.txSh = {1'b1, s_r.txSh[9:1]};
      end
      else
      begin
        s_nxt.txBit = s_r.txBit - 4'h1;
        if (s_r.txBit == 4'h1)
        begin
          s_nxt.txBusy = 1'b0;
          txDone = 1'b1;
        end
      end
    end
    // async receiver: start on falling edge, sample mid bit
    if (asyncMode && s_r.receive_enable)
    begin
      case (s_r.rxPh)
        SPC_IDLE:
        begin
          // falling edge only, so a low stop bit does not restart a frame
          if (!s_r.serial_in_pin[1] && s_r.serial_in_pin[2])
          begin
            s_nxt.rxPh = SPC_START;
            s_nxt.rxTick = 4'h0;
            s_nxt.rxBusy = 1'b1;
            s_nxt.rxBit = (mode == SPC_MODE_A8 ? 4'h8 : 4'h7) + {3'h0, parOn};
          end
        end
        SPC_START, SPC_BITS:
        begin
          if (halfTick)
          begin
            s_nxt.rxTick = s_r.rxTick + 4'h1;
            // even half ticks fall mid-bit: start centre, then each data bit
            if (!s_r.rxTick[0])
            begin
              s_nxt.rxPh = SPC_BITS;
              if (s_r.rxPh == SPC_BITS)
              begin
                s_nxt.rxSh = {s_r.serial_in_pin[1], s_r.rxSh[8:1]};
                s_nxt.rxBit = s_r.rxBit - 4'h1;
                if (s_r.rxBit == 4'h1)
                begin
                  s_nxt.rxPh = SPC_STOP;
                end
              end
            end
          end
        end
        SPC_STOP:
        begin
          if (halfTick && !s_r.rxTick[0])
          begin
            fullAsync = 1'b1;
            s_nxt.rxPh = SPC_IDLE;
            s_nxt.rxBusy = 1'b0;
          end
          else if (halfTick)
          begin
            s_nxt.rxTick = s_r.rxTick + 4'h1;
          end
        end
        default: s_nxt.rxPh = SPC_IDLE;
      endcase
    end
    else
    begin
      s_nxt.rxPh = SPC_IDLE;
    end
    // async frame end: align data, check parity and stop
    if (fullAsync)
    begin
      case ({mode == SPC_MODE_A8, parOn})
        2'b11: dat = s_r.rxSh[7:0];
        2'b10: dat = s_r.rxSh[8:1];
        2'b01: dat = {1'b0, s_r.rxSh[7:1]};
        default: dat = {1'b0, s_r.rxSh[8:2]};
      endcase
      // sum of data and parity bit; parity sits in bit 8 in both modes
      pbit = ^s_r.rxSh[8:1];
      if (mode == SPC_MODE_A8)
      begin
        pbit = ^s_r.rxSh[8:0];
      end
      s_nxt.rxBuf = dat;
      if (s_r.bufFull)
      begin
        s_nxt.ovr = 1'b1;
        ovrSet = 1'b1;
        errEv = 1'b1;
      end
      else
      begin
        s_nxt.bufFull = 1'b1;
        if (parOn && (pbit != oddPar))
        begin
          s_nxt.par = 1'b1;
          parSet = 1'b1;
          errEv = 1'b1;
        end
        if (!s_r.serial_in_pin[1])
        begin
          s_nxt.frm = 1'b1;
          frmSet = 1'b1;
          errEv = 1'b1;
        end
        if (errEv)
        begin
          s_nxt.pendRec = 1'b1;
        end
        else
        begin
          recEv = 1'b1;
        end
      end
    end
    else if (s_r.pendRec && halfTick)
    begin
      s_nxt.pendRec = 1'b0;
      recEv = 1'b1;
    end
    // sync receiver: sample on rising edge, no buffer stage
    if (sync && s_r.rxBusy && clkRise)
    begin
      s_nxt.rxSh = {s_r.serial_in_pin[1], s_r.rxSh[8:1]};
      s_nxt.rxBit = s_r.rxBit - 4'h1;
      if (s_r.rxBit == 4'h1)
      begin
        s_nxt.rxBusy = 1'b0;
        s_nxt.rdyOut = 1'b1;
        s_nxt.rxBuf = {s_r.serial_in_pin[1], s_r.rxSh[8:2]};
        recEv = 1'b1;
      end
    end
    // apb write effects
    if (wrAcc)
    begin
      case (idx)
        SPC_IDX_PRIO: s_nxt.prio = wb;
        SPC_IDX_IEN: s_nxt.ien = wb;
        SPC_IDX_IFLG: s_nxt.iflg = s_r.iflg & ~wb[2:0];
        SPC_IDX_MODE: s_nxt.mode = wb[6:0];
        SPC_IDX_CTRL:
        begin
          s_nxt.transmit_enable = wb[SPC_B_TRANSMIT_ENABLE];
          s_nxt.receive_enable = wb[SPC_B_RECEIVE_ENABLE];
          // a set in the same cycle wins over the clear
          if (wb[SPC_B_OVR] && !ovrSet) s_nxt.ovr = 1'b0;
          if (wb[SPC_B_PAR] && !parSet) s_nxt.par = 1'b0;
          if (wb[SPC_B_FRM] && !frmSet) s_nxt.frm = 1'b0;
          if (wb[SPC_B_TRANSMIT_TRIGGER] && wb[SPC_B_TRANSMIT_ENABLE] && !s_r.txBusy)
          begin
            s_nxt.txBusy = 1'b1;
            s_nxt.txTick = 4'h0;
            s_nxt.txOut = 1'b1;
            if (asyncMode)
            begin
              // start, data, optional parity, stop, lsb first
              s_nxt.txBit = (mode == SPC_MODE_A8 ? 4'h9 : 4'h8) + {3'h0, parOn};
              if (mode == SPC_MODE_A8)
              begin
                s_nxt.txSh = parOn ? {^s_r.txData ^ oddPar, s_r.txData, 1'b0}
                                   : {1'b1, s_r.txData, 1'b0};
              end
              else
              begin
                s_nxt.txSh = parOn ? {1'b1, ^s_r.txData[6:0] ^ oddPar, s_r.txData[6:0], 1'b0}
                                   : {2'h3, s_r.txData[6:0], 1'b0};
              end
            end
            else
            begin
              s_nxt.txBit = 4'h8;
              s_nxt.txSh = {2'h3, s_r.txData};
            end
          end
          if (wb[SPC_B_RECEIVE_TRIGGER] && wb[SPC_B_RECEIVE_ENABLE])
          begin
            if (asyncMode)
            begin
              s_nxt.bufFull = fullAsync;
            end
            else if (!s_r.rxBusy)
            begin
              s_nxt.rxBusy = 1'b1;
              s_nxt.rxBit = 4'h8;
              s_nxt.rdyOut = 1'b0;
            end
          end
        end
        SPC_IDX_DATA: s_nxt.txData = wb;
        default: s_nxt.txData = s_r.txData;
      endcase
    end
    // hardware sets beat software clears
    if (txDone) s_nxt.iflg[SPC_B_TXI] = 1'b1;
    if (recEv) s_nxt.iflg[SPC_B_RXI] = 1'b1;
    if (errEv) s_nxt.iflg[SPC_B_ERI] = 1'b1;
    // disabled transmitter stops
    if (!s_nxt.transmit_enable)
    begin
      s_nxt.txBusy = 1'b0;
      s_nxt.txOut = 1'b1;
    end
    // error flags forced low while reception disabled
    if (!s_nxt.receive_enable)
    begin
      s_nxt.ovr = 1'b0;
      s_nxt.par = 1'b0;
      s_nxt.frm = 1'b0;
      s_nxt.rxBusy = 1'b0;
      s_nxt.bufFull = 1'b0;
      s_nxt.pendRec = 1'b0;
      s_nxt.rdyOut = 1'b1;
    end
    // read data captured in setup phase
    if (rdAcc)
    begin
      case (idx)
        SPC_IDX_PRIO: s_nxt.rdata = {24'h0, s_r.prio};
        SPC_IDX_IEN: s_nxt.rdata = {24'h0, s_r.ien};
        SPC_IDX_IFLG: s_nxt.rdata = {29'h0, s_r.iflg};
        SPC_IDX_MODE: s_nxt.rdata = {25'h0, s_r.mode};
        SPC_IDX_CTRL: s_nxt.rdata = {25'h0, s_r.frm, s_r.par, s_r.ovr,
                                     s_r.rxBusy, s_r.receive_enable, s_r.txBusy, s_r.transmit_enable};
        SPC_IDX_DATA: s_nxt.rdata = {24'h0, s_r.rxBuf};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s_r <= '0;
      s_r.txOut <= 1'b1;
      s_r.clkOut <= 1'b1;
      s_r.rdyOut <= 1'b1;
      s_r.serial_in_pin <= 3'h7;
      s_r.sClk <= 3'h7;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign portSerialSelect = s_r.mode[0];
  assign serialOutPin = s_r.txOut;
  assign shiftClkOut = s_r.clkOut;
  // clock driven only as serial master
  assign shiftClkOe = s_r.mode[0] & (mode == SPC_MODE_MASTER);
  assign readyPinOut = s_r.rdyOut;
  assign readyPinOe = s_r.mode[0] & (mode == SPC_MODE_SLAVE);
  assign serialIrqLevel = s_r.prio[5:4];
  assign irqActive = s_r.iflg & s_r.ien[2:0];
endmodule : spc_serial_port

/* tb/spc_port_chk.sv */
// concurrent checks on the serial port control block's apb and status ports
// assumes one mclk domain with srst synchronous and active high
`timescale 1ns/10ps
module spc_port_chk
  import spc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic portSerialSelect,
  input wire logic [1:0] serialIrqLevel,
  input wire logic [2:0] irqActive
);
  logic [7:0] wdR; // low byte of last cycle's write data
  // keep write data so a check one cycle on can see what was written
  always_ff @(posedge mclk)
  begin
    wdR <= pwdata[7:0];
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  // access edge of a write to one register
  sequence s_wr(logic [17:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  // setup cycle of a read from one register
  sequence s_rd(logic [17:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  property p_ready;
    psel && penable |-> pready && !pslverr;
  endproperty
  a_ready: assert property (p_ready) else $error("access not answered at once");
  property p_level;
    s_wr({SPC_IDX_PRIO, 2'b00}) |=> serialIrqLevel == wdR[5:4];
  endproperty
  a_level: assert property (p_level) else $error("level not taken from write");
  property p_levelRd;
    s_rd({SPC_IDX_PRIO, 2'b00}) |=> prdata[5:4] == serialIrqLevel && prdata[31:8] == 24'h0;
  endproperty
  a_levelRd: assert property (p_levelRd) else $error("level read back wrong");
  property p_sel;
    s_wr({SPC_IDX_MODE, 2'b00}) |=> portSerialSelect == wdR[0];
  endproperty
  a_sel: assert property (p_sel) else $error("terminal select not taken");
  property p_modeRd;
    s_rd({SPC_IDX_MODE, 2'b00}) |=> prdata[0] == portSerialSelect && !prdata[7];
  endproperty
  a_modeRd: assert property (p_modeRd) else $error("mode read back wrong");
  property p_mask;
    s_wr({SPC_IDX_IEN, 2'b00}) |=> (irqActive & ~wdR[2:0]) == 3'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("disabled interrupt active");
  property p_rst;
    $fell(srst) |-> serialIrqLevel == 2'h0 && irqActive == 3'h0 && !portSerialSelect;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_unmapped;
    s_rd({16'hff21, 2'b00}) |=> prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : spc_port_chk

/* tb/spc_far_end.sv */
// remote serial device model: sends and takes asynchronous frames
// assumes the block shifts one bit per BIT_CYC mclk cycles
`timescale 1ns/10ps
module spc_far_end
#(
  parameter int BIT_CYC = 4
)
(
  input wire logic mclk,
  input wire logic serialOutPin,
  output logic serialInPin
);
  logic [7:0] gotByte = 8'h00; // last byte taken from the block
  // line idles high between frames
  initial
  begin
    serialInPin = 1'b1;
  end
  // one frame: start, n data bits lsb first, optional parity, stop
  task automatic send_frame(input logic [7:0] d, input int n, input bit hasPar,
    input logic par, input logic stopBit);
    @(posedge mclk);
    serialInPin <= 1'b0;
    repeat (BIT_CYC) @(posedge mclk);
    for (int i = 0; i < n; i++)
    begin
      serialInPin <= d[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
    if (hasPar)
    begin
      serialInPin <= par;
      repeat (BIT_CYC) @(posedge mclk);
    end
    serialInPin <= stopBit;
    repeat (BIT_CYC) @(posedge mclk);
    serialInPin <= 1'b1;
    repeat (BIT_CYC) @(posedge mclk);
  endtask : send_frame
  // take each frame from the block, sampling mid-bit on the falling edge
  always
  begin
    @(negedge serialOutPin);
    repeat (BIT_CYC + BIT_CYC / 2) @(negedge mclk);
    for (int k = 0; k < 8; k++)
    begin
      gotByte[k] = serialOutPin;
      repeat (BIT_CYC) @(negedge mclk);
    end
  end
endmodule : spc_far_end

/* tb/testbench.sv */
// self-checking bench: register map, async transmit and receive, errors
// assumes oscTick every cycle so divide by 4 gives four cycles per bit
`timescale 1ns/10ps
module testbench
  import spc_pkg::*;
;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, serialInPin, serialOutPin;
  logic [1:0] serialIrqLevel;
  logic [2:0] irqActive;
  int failures = 0;
  int nChecks = 0;
  always #12.5 mclk = ~mclk;
  spc_serial_port dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oscTick(1'b1), .timerTick(1'b0), .serialInPin(serialInPin),
    .shiftClkIn(1'b1), .readyIn(1'b1), .serialOutPin(serialOutPin), .shiftClkOut(),
    .shiftClkOe(), .readyPinOut(), .readyPinOe(), .portSerialSelect(),
    .serialIrqLevel(serialIrqLevel), .irqActive(irqActive));
  spc_far_end far (.mclk(mclk), .serialOutPin(serialOutPin), .serialInPin(serialInPin));
  // compare one byte result
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    nChecks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer: setup, then access held until pready
  task automatic apb(input logic isWr, input logic [15:0] a, input logic [7:0] wd,
    output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= isWr;
    paddr <= {a, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] rd;
    apb(1'b1, a, d, rd);
  endtask : wr
  // read a register and compare the masked bits
  task automatic rdchk(input string nm, input logic [15:0] a, input logic [7:0] m,
    input logic [7:0] e);
    logic [7:0] rd;
    apb(1'b0, a, 8'h00, rd);
    chk(nm, e, rd & m);
  endtask : rdchk
  // poll a flag bit until it reads one, bounded
  task automatic waitbit(input logic [15:0] a, input int b);
    logic [7:0] rd;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, a, 8'h00, rd);
      n++;
    end
    while (rd[b] !== 1'b1 && n < 200);
    if (rd[b] !== 1'b1)
    begin
      failures++;
      $display("BAD flag %0d exp 1 got 0", b);
    end
  endtask : waitbit
  // reset values, unmapped place, readback of mode and level
  task automatic t_reset();
    rdchk("prio", SPC_IDX_PRIO, 8'hff, 8'h00);
    rdchk("ien", SPC_IDX_IEN, 8'hff, 8'h00);
    rdchk("iflg", SPC_IDX_IFLG, 8'hff, 8'h00);
    rdchk("mode", SPC_IDX_MODE, 8'hff, 8'h00);
    rdchk("ctrl", SPC_IDX_CTRL, 8'hff, 8'h00);
    rdchk("unmapped", 16'hff21, 8'hff, 8'h00);
    wr(SPC_IDX_PRIO, 8'h30);
    rdchk("prio rb", SPC_IDX_PRIO, 8'h30, 8'h30);
    chk("level", 8'h03, {6'h0, serialIrqLevel});
    wr(SPC_IDX_MODE, 8'hff);
    rdchk("mode rb", SPC_IDX_MODE, 8'hff, 8'h7f);
    $display("test reset done");
  endtask : t_reset
  // async 8-bit send with divide by 4, done flag and its interrupt
  task automatic t_tx();
    wr(SPC_IDX_MODE, 8'h17);
    wr(SPC_IDX_IEN, 8'h01);
    wr(SPC_IDX_DATA, 8'ha5);
    wr(SPC_IDX_CTRL, 8'h03);
    rdchk("tx busy", SPC_IDX_CTRL, 8'h02, 8'h02);
    waitbit(SPC_IDX_IFLG, SPC_B_TXI);
    chk("tx byte", 8'ha5, far.gotByte);
    rdchk("tx idle", SPC_IDX_CTRL, 8'h02, 8'h00);
    chk("irq", 8'h01, {5'h0, irqActive});
    wr(SPC_IDX_IFLG, 8'h01);
    rdchk("iflg clr", SPC_IDX_IFLG, 8'h07, 8'h00);
    wr(SPC_IDX_IEN, 8'h00);
    wr(SPC_IDX_CTRL, 8'h00);
    $display("test tx done");
  endtask : t_tx
  // async receive: framing, overrun, flags off with rx disabled, parity
  task automatic t_rx();
    wr(SPC_IDX_CTRL, 8'h0c);
    fork
      far.send_frame(8'h3c, 8, 1'b0, 1'b0, 1'b0);
      begin
        repeat (16) @(posedge mclk);
        rdchk("rx busy", SPC_IDX_CTRL, 8'h08, 8'h08);
        waitbit(SPC_IDX_IFLG, SPC_B_RXI);
      end
    join
    rdchk("rx data", SPC_IDX_DATA, 8'hff, 8'h3c);
    rdchk("framing", SPC_IDX_CTRL, 8'h40, 8'h40);
    rdchk("err flag", SPC_IDX_IFLG, 8'h04, 8'h04);
    wr(SPC_IDX_IFLG, 8'h07);
    wr(SPC_IDX_CTRL, 8'h4c);
    rdchk("fer clr", SPC_IDX_CTRL, 8'h40, 8'h00);
    fork
      far.send_frame(8'h81, 8, 1'b0, 1'b0, 1'b1);
      waitbit(SPC_IDX_IFLG, SPC_B_RXI);
    join
    rdchk("rx data2", SPC_IDX_DATA, 8'hff, 8'h81);
    wr(SPC_IDX_IFLG, 8'h07);
    fork
      far.send_frame(8'h42, 8, 1'b0, 1'b0, 1'b1);
      waitbit(SPC_IDX_IFLG, SPC_B_ERI);
    join
    rdchk("overrun", SPC_IDX_CTRL, 8'h10, 8'h10);
    repeat (8) @(posedge mclk);
    rdchk("no done", SPC_IDX_IFLG, 8'h02, 8'h00);
    wr(SPC_IDX_CTRL, 8'h00);
    rdchk("rx off", SPC_IDX_CTRL, 8'h70, 8'h00);
    wr(SPC_IDX_IFLG, 8'h07);
    wr(SPC_IDX_MODE, 8'h55);
    wr(SPC_IDX_CTRL, 8'h0c);
    fork
      far.send_frame(8'h55, 7, 1'b1, 1'b1, 1'b1);
      waitbit(SPC_IDX_IFLG, SPC_B_ERI);
    join
    rdchk("parity", SPC_IDX_CTRL, 8'h20, 8'h20);
    repeat (8) @(posedge mclk);
    rdchk("par done", SPC_IDX_IFLG, 8'h02, 8'h02);
    rdchk("rx7 data", SPC_IDX_DATA, 8'hff, 8'h55);
    wr(SPC_IDX_IFLG, 8'h07);
    wr(SPC_IDX_MODE, 8'h75);
    wr(SPC_IDX_CTRL, 8'h2c);
    fork
      far.send_frame(8'h55, 7, 1'b1, 1'b1, 1'b1);
      waitbit(SPC_IDX_IFLG, SPC_B_RXI);
    join
    rdchk("odd ok", SPC_IDX_CTRL, 8'h20, 8'h00);
    $display("test rx done");
  endtask : t_rx
  // clocked master send with divide by 4: busy, then done flag
  task automatic t_sync();
    wr(SPC_IDX_CTRL, 8'h00);
    wr(SPC_IDX_MODE, 8'h11);
    wr(SPC_IDX_DATA, 8'hc3);
    wr(SPC_IDX_CTRL, 8'h03);
    rdchk("sync busy", SPC_IDX_CTRL, 8'h02, 8'h02);
    waitbit(SPC_IDX_IFLG, SPC_B_TXI);
    rdchk("sync idle", SPC_IDX_CTRL, 8'h02, 8'h00);
    wr(SPC_IDX_CTRL, 8'h00);
    $display("test sync done");
  endtask : t_sync
  // print counts and verdict, then end the run
  task automatic summarize();
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // main sequence: reset for 12 cycles, then the tests
  initial
  begin
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_sync();
    summarize();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge mclk);
    failures++;
    $display("BAD watchdog exp done got hang");
    summarize();
  end
endmodule : testbench
bind spc_serial_port spc_port_chk u_chk (.mclk(mclk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .portSerialSelect(portSerialSelect),
  .serialIrqLevel(serialIrqLevel), .irqActive(irqActive));
